// ===== common/mbw_pkg.sv
// Purpose: Shared types and constants for the memory bus wait/priority block
// Assumes: One processor clock, all CPU and memory side signals on that clock
// Notes:   Region bounds are word addresses on the data bus
package mbw_pkg;

    localparam int NCH      = 3;
    localparam int CH_WR    = 0;
    localparam int CH_RD    = 1;
    localparam int CH_PG    = 2;
    localparam int PADDR_W  = 22;
    localparam int DADDR_W  = 32;
    localparam int DATA_W   = 32;
    localparam int PER_AW   = 16;
    localparam int CNT_W    = 5;

    // Access classes, one-hot position in ack vectors
    localparam logic [2:0] CLS_DW = 3'h0;
    localparam logic [2:0] CLS_PW = 3'h1;
    localparam logic [2:0] CLS_DR = 3'h2;
    localparam logic [2:0] CLS_PR = 3'h3;
    localparam logic [2:0] CLS_FE = 3'h4;

    // Fixed wait-state counts
    localparam logic [CNT_W-1:0] W_ZERO    = 5'h00;
    localparam logic [CNT_W-1:0] W_ONE     = 5'h01;
    localparam logic [CNT_W-1:0] W_PF_RD   = 5'h02;
    localparam logic [CNT_W-1:0] W_PWD     = 5'h10;

    // Region bounds
    localparam logic [31:0] SRAM_A_LO = 32'h0000_0000;
    localparam logic [31:0] SRAM_A_HI = 32'h0000_03ff;
    localparam logic [31:0] SRAM_B_LO = 32'h0000_0400;
    localparam logic [31:0] SRAM_B_HI = 32'h0000_07ff;
    localparam logic [31:0] PF0_LO    = 32'h0000_0800;
    localparam logic [31:0] PF0_HI    = 32'h0000_0fff;
    localparam logic [31:0] PF1_LO    = 32'h0000_6000;
    localparam logic [31:0] PF1_HI    = 32'h0000_6fff;
    localparam logic [31:0] PF2_LO    = 32'h0000_7000;
    localparam logic [31:0] PF2_HI    = 32'h0000_7fff;
    localparam logic [31:0] MAIN_LO   = 32'h0000_8000;
    localparam logic [31:0] MAIN_HI   = 32'h0000_8fff;
    localparam logic [31:0] OTP_LO    = 32'h003d_7800;
    localparam logic [31:0] OTP_HI    = 32'h003d_7bff;
    localparam logic [31:0] FL_LO     = 32'h003f_0000;
    localparam logic [31:0] FL_HI     = 32'h003f_7fff;
    localparam logic [31:0] PWD_LO    = 32'h003f_7ff8;
    localparam logic [31:0] PWD_HI    = 32'h003f_7fff;
    localparam logic [31:0] ROM_LO    = 32'h003f_e000;
    localparam logic [31:0] ROM_HI    = 32'h003f_ffff;

    typedef enum logic [3:0] {
        RG_NONE   = 4'h0,
        RG_SRAM_A = 4'h1,
        RG_SRAM_B = 4'h2,
        RG_PF0    = 4'h3,
        RG_PF1    = 4'h4,
        RG_PF2    = 4'h5,
        RG_MAIN   = 4'h6,
        RG_OTP    = 4'h7,
        RG_FLASH  = 4'h8,
        RG_PWD    = 4'h9,
        RG_ROM    = 4'ha
    } mbw_region_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } mbw_state_t;

    // One CPU access request, held until its ack
    typedef struct packed {
        logic              req;
        logic [31:0]       addr;
        logic [DATA_W-1:0] wdata;
        logic              size32;
    } mbw_acc_t;

    // One memory-side access in progress
    typedef struct packed {
        logic              act;
        mbw_region_t       region;
        logic [31:0]       addr;
        logic              wr;
        logic [DATA_W-1:0] wdata;
        logic              size32;
    } mbw_mem_t;

    // Peripheral bridge bus
    typedef struct packed {
        logic [PER_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
        logic              size32;
        mbw_region_t       frame;
    } mbw_per_t;

endpackage : mbw_pkg

// ===== core/mbw_top.sv
// Purpose: Memory bus access arbitration and wait-state generation
// Assumes: Requests and ready come from logic on mclk; requests held to ack
// Notes:   Three channels: write bus, data read bus, program read bus
`timescale 1ns/10ps
module mbw_top
    import mbw_pkg::*;
#(
    parameter int CFG_W    = 4,
    parameter int PAGE_LSB = 3
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rst_n,
    // Processor access requests
    input  wire mbw_acc_t            dw_acc,
    input  wire mbw_acc_t            pw_acc,
    input  wire mbw_acc_t            dr_acc,
    input  wire mbw_acc_t            pr_acc,
    input  wire mbw_acc_t            fe_acc,
    // Processor answers
    output logic [4:0]               ack_q,
    output logic [4:0]               err_q,
    output logic [DATA_W-1:0]        drd_data_q,
    output logic [DATA_W-1:0]        prd_data_q,
    // Flash and OTP wait configuration
    input  wire logic [CFG_W-1:0]    otp_wait,
    input  wire logic [CFG_W-1:0]    flash_page_wait,
    input  wire logic [CFG_W-1:0]    flash_rand_wait,
    // Memory side
    output mbw_mem_t                 mem_q [NCH],
    input  wire logic [DATA_W-1:0]   mem_rdata [NCH],
    // Peripheral bridge
    output mbw_per_t                 per_q,
    input  wire logic                per_ready,
    input  wire logic [DATA_W-1:0]   per_rdata
);

    if (CFG_W < 1 || CFG_W > 4) begin : g_bad_cfg
        $error("mbw_top: CFG_W must be 1..4");
    end
    if (PAGE_LSB < 1 || PAGE_LSB > 12) begin : g_bad_page
        $error("mbw_top: PAGE_LSB must be 1..12");
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic mbw_region_t decode(input logic [31:0] a);
        mbw_region_t r;
        r = RG_NONE;
        if (a >= SRAM_A_LO && a <= SRAM_A_HI) r = RG_SRAM_A;
        else if (a >= SRAM_B_LO && a <= SRAM_B_HI) r = RG_SRAM_B;
        else if (a >= PF0_LO && a <= PF0_HI) r = RG_PF0;
        else if (a >= PF1_LO && a <= PF1_HI) r = RG_PF1;
        else if (a >= PF2_LO && a <= PF2_HI) r = RG_PF2;
        else if (a >= MAIN_LO && a <= MAIN_HI) r = RG_MAIN;
        else if (a >= OTP_LO && a <= OTP_HI) r = RG_OTP;
        else if (a >= PWD_LO && a <= PWD_HI) r = RG_PWD;
        else if (a >= FL_LO && a <= FL_HI) r = RG_FLASH;
        else if (a >= ROM_LO && a <= ROM_HI) r = RG_ROM;
        return r;
    endfunction : decode

    // Peripheral frames share the one bridge
    function automatic logic is_pf(input mbw_region_t r);
        return (r == RG_PF0) || (r == RG_PF1) || (r == RG_PF2);
    endfunction : is_pf

    function automatic logic same_grp(input mbw_region_t a, input mbw_region_t b);
        return (a != RG_NONE) && ((a == b) || (is_pf(a) && is_pf(b)));
    endfunction : same_grp

    ////////////////////////////////////////////////////////////////////////
    // Effective flash/OTP waits
    logic [CNT_W-1:0] otp_eff, page_eff, rand_eff, rand_one;
    always_comb begin
        page_eff = CNT_W'(flash_page_wait);
        otp_eff  = (otp_wait == '0) ? W_ONE : CNT_W'(otp_wait);
        rand_one = (flash_rand_wait == '0) ? W_ONE : CNT_W'(flash_rand_wait);
        rand_eff = (rand_one < page_eff) ? page_eff : rand_one;
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel selection
    mbw_acc_t    ch_acc [NCH];
    logic [2:0]  ch_cls [NCH];
    logic        ch_psp [NCH];
    mbw_region_t ch_reg [NCH];
    always_comb begin
        ch_acc[CH_WR] = dw_acc.req ? dw_acc : pw_acc;
        ch_cls[CH_WR] = dw_acc.req ? CLS_DW : CLS_PW;
        ch_psp[CH_WR] = !dw_acc.req;
        ch_acc[CH_RD] = dr_acc;
        ch_cls[CH_RD] = CLS_DR;
        ch_psp[CH_RD] = 1'b0;
        ch_acc[CH_PG] = pr_acc.req ? pr_acc : fe_acc;
        ch_cls[CH_PG] = pr_acc.req ? CLS_PR : CLS_FE;
        ch_psp[CH_PG] = 1'b1;
        for (int i = 0; i < NCH; i++) begin
            if (ch_psp[i]) begin
                ch_acc[i].addr = DADDR_W'(ch_acc[i].addr[PADDR_W-1:0]);
            end
            ch_reg[i] = decode(ch_acc[i].addr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel state machines
    mbw_state_t       st_q [NCH], st_d [NCH];
    mbw_region_t      rg_q [NCH], rg_d [NCH];
    logic [CNT_W-1:0] cnt_q [NCH], cnt_d [NCH];
    logic [2:0]       cls_q [NCH], cls_d [NCH];
    logic [NCH-1:0]   bad_q, bad_d, wr_q, wr_d;
    mbw_acc_t         acc_q [NCH], acc_d [NCH];
    logic [4:0]       ack_d, err_d;
    logic [DATA_W-1:0] drd_d, prd_d, rdv;
    logic [PER_AW+PAGE_LSB-1:PAGE_LSB] pg_q, pg_d;
    logic             pgv_q, pgv_d, blk;
    logic [NCH-1:0]   grant;

    always_comb begin
        pg_d  = pg_q;
        pgv_d = pgv_q;
        ack_d = '0;
        err_d = '0;
        drd_d = drd_data_q;
        prd_d = prd_data_q;
        grant = '0;
        rdv   = '0;
        blk   = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            st_d[i]  = st_q[i];
            rg_d[i]  = rg_q[i];
            cnt_d[i] = cnt_q[i];
            cls_d[i] = cls_q[i];
            acc_d[i] = acc_q[i];
            bad_d[i] = bad_q[i];
            wr_d[i]  = wr_q[i];
            unique case (st_q[i])
                ST_IDLE: begin
                    blk = 1'b0;
                    for (int j = 0; j < NCH; j++) begin
                        if (j != i && st_q[j] == ST_WAIT && same_grp(rg_q[j], ch_reg[i])) begin
                            blk = 1'b1;
                        end
                        if (j < i && ch_acc[j].req && st_q[j] == ST_IDLE && !ack_q[cls_q[j]]
                            && same_grp(ch_reg[j], ch_reg[i])) begin
                            blk = 1'b1;
                        end
                    end
                    if (ch_acc[i].req && !blk && !ack_q[cls_q[i]]) begin
                        grant[i] = 1'b1;
                        st_d[i]  = ST_WAIT;
                        cls_d[i] = ch_cls[i];
                        acc_d[i] = ch_acc[i];
                        wr_d[i]  = (i == CH_WR);
                        rg_d[i]  = ch_reg[i];
                        bad_d[i] = (ch_reg[i] == RG_NONE)
                                 || (is_pf(ch_reg[i]) && ch_psp[i])
                                 || (ch_reg[i] == RG_PF2 && ch_acc[i].size32);
                        unique case (ch_reg[i])
                            RG_PF1, RG_PF2: cnt_d[i] = wr_d[i] ? W_ZERO : W_PF_RD;
                            RG_OTP:   cnt_d[i] = otp_eff;
                            RG_PWD:   cnt_d[i] = W_PWD;
                            RG_FLASH: begin
                                cnt_d[i] = (pgv_q && pg_q == ch_acc[i].addr[PER_AW+PAGE_LSB-1:PAGE_LSB])
                                         ? page_eff : rand_eff;
                                pg_d  = ch_acc[i].addr[PER_AW+PAGE_LSB-1:PAGE_LSB];
                                pgv_d = 1'b1;
                            end
                            default:  cnt_d[i] = W_ZERO;
                        endcase
                        if (bad_d[i]) begin
                            rg_d[i]  = RG_NONE;
                            cnt_d[i] = W_ZERO;
                        end
                    end
                end
                ST_WAIT: begin
                    if (cnt_q[i] != W_ZERO) begin
                        cnt_d[i] = cnt_q[i] - W_ONE;
                    end else if (rg_q[i] != RG_PF1 || per_ready) begin
                        st_d[i]          = ST_IDLE;
                        ack_d[cls_q[i]]  = 1'b1;
                        err_d[cls_q[i]]  = bad_q[i];
                        rdv = is_pf(rg_q[i]) ? per_rdata : mem_rdata[i];
                        if (rg_q[i] == RG_PF2) begin
                            rdv = {16'h0000, rdv[15:0]};
                        end
                        if (bad_q[i]) begin
                            rdv = '0;
                        end
                        if (i == CH_RD) drd_d = rdv;
                        if (i == CH_PG) prd_d = rdv;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory side and peripheral bridge outputs
    mbw_mem_t mem_d [NCH];
    mbw_per_t per_d;
    always_comb begin
        per_d = '0;
        for (int i = 0; i < NCH; i++) begin
            mem_d[i]        = '0;
            mem_d[i].act    = (st_d[i] == ST_WAIT) && !is_pf(rg_d[i]) && rg_d[i] != RG_NONE;
            mem_d[i].region = rg_d[i];
            mem_d[i].addr   = acc_d[i].addr;
            mem_d[i].wr     = wr_d[i];
            mem_d[i].wdata  = acc_d[i].wdata;
            mem_d[i].size32 = acc_d[i].size32;
            if (st_d[i] == ST_WAIT && is_pf(rg_d[i])) begin
                per_d.addr   = acc_d[i].addr[PER_AW-1:0];
                per_d.wdata  = acc_d[i].wdata;
                per_d.wr     = wr_d[i];
                per_d.rd     = !wr_d[i];
                per_d.size32 = acc_d[i].size32;
                per_d.frame  = rg_d[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NCH; i++) begin
                st_q[i]  <= ST_IDLE;
                rg_q[i]  <= RG_NONE;
                cnt_q[i] <= W_ZERO;
                cls_q[i] <= CLS_DW;
                acc_q[i] <= '0;
                mem_q[i] <= '0;
            end
            bad_q      <= '0;
            wr_q       <= '0;
            ack_q      <= '0;
            err_q      <= '0;
            drd_data_q <= '0;
            prd_data_q <= '0;
            pg_q       <= '0;
            pgv_q      <= 1'b0;
            per_q      <= '0;
        end else begin
            st_q       <= st_d;
            rg_q       <= rg_d;
            cnt_q      <= cnt_d;
            cls_q      <= cls_d;
            acc_q      <= acc_d;
            mem_q      <= mem_d;
            bad_q      <= bad_d;
            wr_q       <= wr_d;
            ack_q      <= ack_d;
            err_q      <= err_d;
            drd_data_q <= drd_d;
            prd_data_q <= prd_d;
            pg_q       <= pg_d;
            pgv_q      <= pgv_d;
            per_q      <= per_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_write_prio: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_q[CH_WR] == ST_IDLE && dw_acc.req && pw_acc.req && grant[CH_WR])
        |=> cls_q[CH_WR] == CLS_DW) else $error("program write beat data write");
    chk_fetch_yield: assert property (@(posedge mclk) disable iff (!rst_n)
        (grant[CH_PG] && pr_acc.req) |=> cls_q[CH_PG] == CLS_PR)
        else $error("fetch beat program read");
    chk_pf1_read: assert property (@(posedge mclk) disable iff (!rst_n)
        (grant[CH_RD] && ch_reg[CH_RD] == RG_PF1) |=> cnt_q[CH_RD] == W_PF_RD ##2
        (st_q[CH_RD] == ST_WAIT && cnt_q[CH_RD] == W_ZERO))
        else $error("frame 1 read wait count wrong");
    chk_pf2_fixed: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_q[CH_RD] == ST_WAIT && rg_q[CH_RD] == RG_PF2 && cnt_q[CH_RD] == W_ZERO)
        |=> ack_q[CLS_DR]) else $error("frame 2 stretched by ready");
    chk_otp_min: assert property (@(posedge mclk) disable iff (!rst_n)
        (grant[CH_RD] && ch_reg[CH_RD] == RG_OTP) |=> cnt_q[CH_RD] >= W_ONE && !ack_q[CLS_DR])
        else $error("otp waits below one");
    chk_flash_rand: assert property (@(posedge mclk) disable iff (!rst_n)
        rand_eff >= page_eff && rand_eff >= W_ONE) else $error("flash random wait too small");
    chk_pwd_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        (grant[CH_PG] && ch_reg[CH_PG] == RG_PWD) |=> cnt_q[CH_PG] == W_PWD)
        else $error("password waits not sixteen");
    chk_zero_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        (grant[CH_PG] && !pr_acc.req && (ch_reg[CH_PG] == RG_SRAM_A || ch_reg[CH_PG] == RG_MAIN
        || ch_reg[CH_PG] == RG_ROM)) |=> ##1 ack_q[CLS_FE]) else $error("fixed region waited");
    chk_prog_no_pf: assert property (@(posedge mclk) disable iff (!rst_n)
        (grant[CH_PG] && is_pf(ch_reg[CH_PG])) |=> !per_q.rd && !mem_q[CH_PG].act
        && bad_q[CH_PG]) else $error("program space reached a frame");
    chk_pf2_narrow: assert property (@(posedge mclk) disable iff (!rst_n)
        per_q.frame == RG_PF2 |-> !per_q.size32) else $error("32-bit access on frame 2");
    chk_write_first: assert property (@(posedge mclk) disable iff (!rst_n)
        (st_q[CH_WR] == ST_WAIT && is_pf(rg_q[CH_WR])) |-> !(st_q[CH_RD] == ST_WAIT
        && is_pf(rg_q[CH_RD]))) else $error("frame read overlapped write");

endmodule : mbw_top

// ===== tb/mbw_far_model.sv
// Purpose: Far-side model of memories and peripheral frames
// Assumes: Read data follows a fixed address pattern
// Notes:   Ready rises rdy_dly cycles into a peripheral access
`timescale 1ns/10ps
module mbw_far_model
    import mbw_pkg::*;
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_n,
    // Block side
    input  wire mbw_mem_t      mem_q [NCH],
    input  wire mbw_per_t      per_q,
    input  wire logic [3:0]    rdy_dly,
    // Answers
    output logic [DATA_W-1:0]  mem_rdata [NCH],
    output logic               per_ready,
    output logic [DATA_W-1:0]  per_rdata
);
    logic [3:0]        cnt_q;
    logic [DATA_W-1:0] last_q [NCH];
    logic [DATA_W-1:0] plast_q;
    logic              busy;

    assign busy = per_q.rd || per_q.wr;
    assign per_ready = busy && (cnt_q >= rdy_dly);
    assign per_rdata = per_q.rd ? {per_q.addr ^ 16'h5a5a, per_q.addr} : ~plast_q;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            plast_q <= 32'h0;
        end else begin
            cnt_q <= (busy && cnt_q != 4'hf) ? cnt_q + 4'h1 : (busy ? cnt_q : 4'h0);
            plast_q <= per_rdata;
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_mem
        // Idle lines show a changing pattern, never the last word
        assign mem_rdata[c] = mem_q[c].act ? {mem_q[c].addr[15:0] ^ 16'h5a5a,
                              mem_q[c].addr[15:0]} : ~last_q[c];
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                last_q[c] <= '0;
            end else begin
                last_q[c] <= mem_rdata[c];
            end
        end
    end
endmodule : mbw_far_model

// ===== tb/memory_bus_wait_priority_test.sv
// Purpose: Self-checking bench for the memory bus wait/priority block
// Assumes: Far-side model answers memory and peripheral accesses
// Notes:   Waits measured as edges from request drive to ack
`timescale 1ns/10ps
module memory_bus_wait_priority_test;
    import mbw_pkg::*;
    logic              mclk;
    logic              rst_n;
    mbw_acc_t          acc [5];
    logic [4:0]        ack_q;
    logic [4:0]        err_q;
    logic [31:0]       drd;
    logic [31:0]       prd;
    logic [3:0]        otp_w;
    logic [3:0]        pg_w;
    logic [3:0]        rnd_w;
    logic [3:0]        rdy_dly;
    mbw_mem_t          mem_q [NCH];
    logic [31:0]       mem_rdata [NCH];
    mbw_per_t          per_q;
    logic              per_ready;
    logic [31:0]       per_rdata;
    int                err_count;
    int                compares;

    mbw_top DUT (.mclk(mclk), .rst_n(rst_n), .dw_acc(acc[0]), .pw_acc(acc[1]),
        .dr_acc(acc[2]), .pr_acc(acc[3]), .fe_acc(acc[4]), .ack_q(ack_q), .err_q(err_q),
        .drd_data_q(drd), .prd_data_q(prd), .otp_wait(otp_w), .flash_page_wait(pg_w),
        .flash_rand_wait(rnd_w), .mem_q(mem_q), .mem_rdata(mem_rdata), .per_q(per_q),
        .per_ready(per_ready), .per_rdata(per_rdata));
    mbw_far_model far (.mclk(mclk), .rst_n(rst_n), .mem_q(mem_q), .per_q(per_q),
        .rdy_dly(rdy_dly), .mem_rdata(mem_rdata), .per_ready(per_ready),
        .per_rdata(per_rdata));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tally_and_finish;
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic access(input int cls, input logic [31:0] a, input logic sz,
                          output int lat, output logic e, output logic [31:0] d);
        lat = 0;
        @(posedge mclk);
        acc[cls] <= '{req: 1'b1, addr: a, wdata: ~a, size32: sz};
        do begin
            @(posedge mclk);
            #1;
            lat++;
        end while (ack_q[cls] !== 1'b1 && lat < 100);
        check("ack seen", 32'h1, {31'h0, ack_q[cls]});
        e = err_q[cls];
        d = (cls == 2) ? drd : prd;
        acc[cls].req <= 1'b0;
    endtask : access

    task automatic run(input int cls, input logic [31:0] a, input logic sz, input int n,
                       input string nm);
        int          lat;
        logic        e;
        logic [31:0] d;
        logic [31:0] m;
        m = sz ? 32'hffff_ffff : 32'h0000_ffff;
        access(cls, a, sz, lat, e, d);
        check({nm, " waits"}, n, lat);
        check({nm, " err"}, 32'h0, {31'h0, e});
        if (cls >= 2) begin
            check({nm, " data"}, {a[15:0] ^ 16'h5a5a, a[15:0]} & m, d & m);
        end
    endtask : run

    task automatic pair(input int c1, input logic [31:0] a1, input int c2,
                        input logic [31:0] a2, input string nm);
        int          l1;
        int          l2;
        logic        e;
        logic [31:0] d;
        fork
            access(c1, a1, 1'b0, l1, e, d);
            access(c2, a2, 1'b0, l2, e, d);
        join
        check({nm, " first"}, 32'h2, l1);
        check({nm, " later"}, 32'h1, {31'h0, l2 > l1});
    endtask : pair

    task automatic cfg(input logic [3:0] o, input logic [3:0] p, input logic [3:0] r);
        @(posedge mclk);
        otp_w <= o;
        pg_w <= p;
        rnd_w <= r;
    endtask : cfg

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_fixed;
        run(2, 32'h0000_0010, 1'b1, 2, "sram a read");
        run(4, 32'h0000_0410, 1'b1, 2, "sram b fetch");
        run(2, 32'h0000_0810, 1'b0, 2, "pf0 read");
        run(4, 32'h003f_e010, 1'b1, 2, "rom fetch");
        run(3, 32'h0000_8010, 1'b1, 2, "main prog read");
        run(0, 32'h0000_8010, 1'b1, 2, "main write");
        run(0, 32'h0000_6010, 1'b0, 2, "pf1 write");
        run(2, 32'h0000_6010, 1'b1, 4, "pf1 read32");
        run(0, 32'h0000_7010, 1'b0, 2, "pf2 write");
        run(2, 32'h0000_7010, 1'b0, 4, "pf2 read");
        check("pf2 upper lanes", 32'h0, drd & 32'hffff_0000);
    endtask : t_fixed

    task automatic t_stretch;
        @(posedge mclk);
        rdy_dly <= 4'h5;
        run(2, 32'h0000_6020, 1'b1, 7, "pf1 slow read");
        run(0, 32'h0000_6020, 1'b1, 7, "pf1 slow write");
        run(2, 32'h0000_7020, 1'b0, 4, "pf2 no ready read");
        run(0, 32'h0000_7020, 1'b0, 2, "pf2 no ready write");
        @(posedge mclk);
        rdy_dly <= 4'h0;
    endtask : t_stretch

    task automatic t_config;
        cfg(4'h0, 4'h0, 4'h0);
        run(2, 32'h003d_7810, 1'b1, 3, "otp clamp");
        run(2, 32'h003f_0010, 1'b1, 3, "flash rand clamp");
        run(2, 32'h003f_0011, 1'b1, 2, "flash page zero");
        cfg(4'h3, 4'h4, 4'h2);
        run(2, 32'h003d_7810, 1'b1, 5, "otp three");
        run(2, 32'h003f_1000, 1'b1, 6, "flash rand raised");
        cfg(4'h3, 4'h1, 4'h3);
        run(2, 32'h003f_2000, 1'b1, 5, "flash rand three");
        run(2, 32'h003f_2001, 1'b1, 3, "flash page one");
        run(2, 32'h003f_7ff8, 1'b1, 18, "password");
        run(4, 32'h003f_7ffc, 1'b1, 18, "password fetch");
    endtask : t_config

    task automatic t_concurrent;
        fork
            run(0, 32'h0000_0020, 1'b1, 2, "cc write");
            run(2, 32'h0000_0420, 1'b1, 2, "cc read");
            run(4, 32'h0040_8020, 1'b1, 2, "cc fetch");
        join
    endtask : t_concurrent

    task automatic t_priority;
        pair(0, 32'h0000_0030, 1, 32'h0000_0030, "dw over pw");
        pair(2, 32'h0000_8030, 4, 32'h0000_8030, "dr over fe");
        pair(3, 32'h0000_0430, 4, 32'h0000_0434, "pr over fe");
        pair(0, 32'h0000_6030, 2, 32'h0000_7030, "write before read");
    endtask : t_priority

    task automatic t_errors;
        int          lat;
        logic        e;
        logic [31:0] d;
        access(3, 32'h0000_6040, 1'b0, lat, e, d);
        check("prog frame err", 32'h1, {31'h0, e});
        check("prog frame data", 32'h0, d);
        check("prog frame waits", 32'h2, lat);
        access(1, 32'h0000_6050, 1'b0, lat, e, d);
        check("prog write frame err", 32'h1, {31'h0, e});
        access(2, 32'h0000_7040, 1'b1, lat, e, d);
        check("pf2 wide err", 32'h1, {31'h0, e});
    endtask : t_errors

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        otp_w = 4'h1;
        pg_w = 4'h0;
        rnd_w = 4'h1;
        rdy_dly = 4'h0;
        foreach (acc[i]) acc[i] = '0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        check("ack after reset", 32'h0, {27'h0, ack_q});
        t_fixed();
        t_stretch();
        t_config();
        t_concurrent();
        t_priority();
        t_errors();
        tally_and_finish();
    end
endmodule : memory_bus_wait_priority_test
